// file: inc/osdlsc_pkg.sv
/*
 Constants, register map and carrier types for the line and screen
 control block of the on-screen display. Assumes one 10 MHz core clock.
*/
package osdlsc_pkg;
   localparam int NLINES = 12;
   localparam logic [3:0] LAST_COL = 4'hb;
   // Byte offsets on the register bus
   localparam logic [4:0] OFF_COLUMN = 5'h00;
   localparam logic [4:0] OFF_LINE1 = 5'h04;
   localparam logic [4:0] OFF_LINE2 = 5'h08;
   localparam logic [4:0] OFF_SCREEN1 = 5'h0c;
   localparam logic [4:0] OFF_SCREEN2 = 5'h10;
   localparam logic [4:0] OFF_VSTART = 5'h14;
   localparam logic [4:0] OFF_HSTART = 5'h18;
   localparam logic [4:0] OFF_STATUS = 5'h1c;
   // Field positions inside the command words
   localparam int L1_OFS = 8;
   localparam int L1_SIZE = 3;
   localparam int L1_SIDE = 2;
   localparam int L1_DOWN = 1;
   localparam int L1_UP = 0;
   localparam int L2_CHROMA = 4;
   localparam int S1_INV = 10;
   localparam int S1_CBG = 9;
   localparam int S1_BLINK = 8;
   localparam int S1_SPACE = 3;
   localparam int S1_K24 = 2;
   localparam int S1_PMODE = 1;
   localparam int S1_DC = 0;
   localparam int S2_SPR = 10;
   localparam int S2_CHR = 9;
   localparam int S2_CBG = 8;
   localparam int S2_HL = 6;
   localparam int S2_UC = 5;
   localparam int S2_UON = 4;
   // Geometry and timing counts in dots, shade colors and a reset zero
   localparam logic [3:0] SHIFT_DW = 4'h3;
   localparam logic [3:0] SHIFT_QW = 4'h9;
   localparam logic [10:0] OFS_STEP_DOTS = 11'h030;
   localparam logic [4:0] CELL_LAST_X = 5'h17;
   localparam logic [5:0] FRAME_TALL = 6'h20;
   localparam logic [5:0] FRAME_SHORT = 6'h18;
   localparam logic [3:0] EDGE_LIGHT = 4'hf;
   localparam logic [3:0] EDGE_DARK = 4'h8;
   localparam logic [3:0] SHADE_FILL = 4'h7;
   localparam logic [3:0] RST_ZERO4 = 4'h0;

   typedef enum logic [2:0] {
      OSDLSC_SZ_NORMAL = 3'h0,
      OSDLSC_SZ_DW = 3'h1,
      OSDLSC_SZ_DH = 3'h2,
      OSDLSC_SZ_DHDW = 3'h3,
      OSDLSC_SZ_QW = 3'h4,
      OSDLSC_SZ_DHQW = 3'h6
   } osdlsc_size_t;

   typedef struct packed {
      logic [2:0] line_hstart_offset;
      logic [2:0] glyph_size_select;
      logic shade_side_join;
      logic shade_down_join;
      logic shade_up_join;
      logic pattern_bg_chroma;
      logic [3:0] pattern_bg_color;
   } osdlsc_line_t;

   // One dot of the renderer, sampled each core clock
   typedef struct packed {
      logic active;
      logic [3:0] line_idx;
      logic [4:0] cell_x;
      logic [4:0] cell_y;
      logic font_bit;
      logic font_nbr;
      logic qualify_flag;
      logic shade_flag;
      logic left_shade;
      logic right_shade;
      logic blink_phase;
      logic [3:0] char_color;
      logic [3:0] char_bg_color;
      logic sprite_dot;
      logic [3:0] sprite_color;
   } osdlsc_dot_t;

   typedef struct packed {
      logic [10:0] line_hstart_dots;
      logic [2:0] glyph_size_select;
      logic [7:0] vstart_dots;
      logic [4:0] spacing_dots;
      logic [5:0] shadow_frame_height;
   } osdlsc_timing_t;
endpackage

// file: src/osdlsc_top.sv
/*
 Line and screen control for the on-screen display: Avalon-MM register
 slave, twelve-entry line memory and the per-dot color/blanking stage.
 Assumes dot inputs synchronous to core_clk and a renderer that reads
 the timing outputs back for its counters.
*/
`timescale 1ns/1ns
module osdlsc_top
   import osdlsc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire osdlsc_dot_t dot_in,
   output logic red_out,
   output logic green_out,
   output logic blue_out,
   output logic intensity_out,
   output logic color_select_out,
   output logic all_output_blank,
   output logic specified_char_blank,
   output osdlsc_timing_t timing_out
);
   osdlsc_line_t line_ram [NLINES];
   osdlsc_line_t line_hold_reg;
   logic [3:0] column_reg;
   logic [10:0] screen1_reg;
   logic [10:0] screen2_reg;
   logic [6:0] vstart_reg;
   logic [6:0] hbase_reg;
   logic wait_reg;
   logic [31:0] rdata_reg;
   logic take;
   logic wr_line2;
   osdlsc_line_t cur_line;
   osdlsc_line_t new_entry;
   logic [3:0] color_next;
   logic csel_next;
   logic blank_next;
   logic spec_next;

   // Extra dots of horizontal delay caused by the widened clock
   function automatic logic [3:0] size_shift(input logic [2:0] s);
      case (s)
         OSDLSC_SZ_DW, OSDLSC_SZ_DHDW: size_shift = SHIFT_DW;
         OSDLSC_SZ_QW, OSDLSC_SZ_DHQW: size_shift = SHIFT_QW;
         default: size_shift = RST_ZERO4;
      endcase
   endfunction

   // Forbidden size codes fall back to normal size
   function automatic logic [2:0] size_clean(input logic [2:0] s);
      case (s)
         OSDLSC_SZ_NORMAL, OSDLSC_SZ_DW, OSDLSC_SZ_DH,
         OSDLSC_SZ_DHDW, OSDLSC_SZ_QW, OSDLSC_SZ_DHQW: size_clean = s;
         default: size_clean = OSDLSC_SZ_NORMAL;
      endcase
   endfunction

   // Request is accepted on the edge where waitrequest reads low
   assign take = (avs_read | avs_write) & ~wait_reg;
   assign wr_line2 = take & avs_write & (avs_address == OFF_LINE2);
   assign new_entry = {line_hold_reg[13:5], avs_writedata[L2_CHROMA:0]};

   // One wait cycle per access keeps read data registered
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
         wait_reg <= 1'b1;
      else
         wait_reg <= ~((avs_read | avs_write) & wait_reg);
   end

   // Read mux; unmapped addresses answer zero
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
         rdata_reg <= 32'h0;
      else if (avs_read & wait_reg)
      begin
         case (avs_address)
            OFF_COLUMN: rdata_reg <= {28'h0, column_reg};
            OFF_LINE1: rdata_reg <= {18'h0, line_hold_reg};
            OFF_SCREEN1: rdata_reg <= {21'h0, screen1_reg};
            OFF_SCREEN2: rdata_reg <= {21'h0, screen2_reg};
            OFF_VSTART: rdata_reg <= {25'h0, vstart_reg};
            OFF_HSTART: rdata_reg <= {25'h0, hbase_reg};
            OFF_STATUS: rdata_reg <= {21'h0, timing_out.line_hstart_dots};
            default: rdata_reg <= 32'h0;
         endcase
      end
   end

   // First line word waits here until the second arrives
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
         line_hold_reg <= '0;
      else if (take & avs_write & (avs_address == OFF_LINE1))
      begin
         line_hold_reg.line_hstart_offset <= avs_writedata[L1_OFS +: 3];
         line_hold_reg.glyph_size_select <= size_clean(avs_writedata[L1_SIZE +: 3]);
         line_hold_reg.shade_side_join <= avs_writedata[L1_SIDE];
         line_hold_reg.shade_down_join <= avs_writedata[L1_DOWN];
         line_hold_reg.shade_up_join <= avs_writedata[L1_UP];
         line_hold_reg.pattern_bg_chroma <= 1'b0;
         line_hold_reg.pattern_bg_color <= RST_ZERO4;
      end
   end

   // Column pointer; software sets it, second line word bumps it
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
         column_reg <= RST_ZERO4;
      else if (take & avs_write & (avs_address == OFF_COLUMN))
         column_reg <= avs_writedata[3:0];
      else if (wr_line2)
         column_reg <= (column_reg >= LAST_COL) ? RST_ZERO4 : column_reg + 4'h1;
   end

   // Line memory; an out-of-range column write is dropped
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         for (int i = 0; i < NLINES; i++)
            line_ram[i] <= '0;
      end
      else if (wr_line2 && column_reg <= LAST_COL)
         line_ram[column_reg] <= new_entry;
   end

   // Screen-wide settings persist until the next write of each word
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         screen1_reg <= 11'h0;
         screen2_reg <= 11'h0;
         vstart_reg <= 7'h0;
         hbase_reg <= 7'h0;
      end
      else if (take & avs_write)
      begin
         case (avs_address)
            OFF_SCREEN1: screen1_reg <= avs_writedata[10:0];
            OFF_SCREEN2: screen2_reg <= avs_writedata[10:0];
            OFF_VSTART: vstart_reg <= avs_writedata[6:0];
            OFF_HSTART: hbase_reg <= avs_writedata[6:0];
            default: ;
         endcase
      end
   end

   // Entry for the line being drawn; index past the last reads as zero
   always_comb
   begin
      cur_line = '0;
      if (dot_in.line_idx <= LAST_COL)
         cur_line = line_ram[dot_in.line_idx];
   end

   // Line and screen geometry handed to the dot counters
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
         timing_out <= '0;
      else
      begin
         timing_out.line_hstart_dots <= {1'b0, hbase_reg, 3'h0}
            + 11'(cur_line.line_hstart_offset) * OFS_STEP_DOTS
            + 11'(size_shift(cur_line.glyph_size_select));
         timing_out.glyph_size_select <= cur_line.glyph_size_select;
         timing_out.vstart_dots <= {vstart_reg, 1'b0};
         timing_out.spacing_dots <= {screen1_reg[S1_SPACE +: 4], 1'b0};
         timing_out.shadow_frame_height <= screen1_reg[S1_K24] ? FRAME_SHORT
            : FRAME_TALL;
      end
   end

   // Dot source priority: sprite, character, pattern, shade, background
   always_comb
   begin
      logic [5:0] frame_h;
      logic chr_dot;
      logic pat_dot;
      logic shade_on;
      logic light;
      logic dark;
      logic inv;
      frame_h = screen1_reg[S1_K24] ? FRAME_SHORT : FRAME_TALL;
      chr_dot = dot_in.font_bit & ~(screen1_reg[S1_BLINK] & dot_in.qualify_flag
         & dot_in.blink_phase);
      pat_dot = screen1_reg[S1_PMODE] & ~dot_in.font_bit & dot_in.font_nbr;
      shade_on = dot_in.shade_flag & ({1'b0, dot_in.cell_y} < frame_h);
      light = (dot_in.cell_y == 5'h0 & ~cur_line.shade_up_join)
         | (dot_in.cell_x == 5'h0 & (cur_line.shade_side_join
         | ~dot_in.left_shade));
      dark = ({1'b0, dot_in.cell_y} == frame_h - 6'h1 & ~cur_line.shade_down_join)
         | (dot_in.cell_x == CELL_LAST_X & (cur_line.shade_side_join
         | ~dot_in.right_shade));
      inv = screen1_reg[S1_INV] & dot_in.shade_flag & dot_in.qualify_flag;
      color_next = RST_ZERO4;
      csel_next = screen2_reg[S2_UC];
      blank_next = 1'b0;
      if (!screen1_reg[S1_DC] || !dot_in.active)
      begin
         // Display off: screen background only
         if (screen2_reg[S2_UON])
            color_next = screen2_reg[3:0];
      end
      else if (dot_in.sprite_dot)
      begin
         color_next = dot_in.sprite_color;
         csel_next = screen2_reg[S2_SPR];
         blank_next = 1'b1;
      end
      else if (chr_dot)
      begin
         color_next = inv ? ~dot_in.char_color : dot_in.char_color;
         csel_next = screen2_reg[S2_CHR];
         blank_next = 1'b1;
      end
      else if (pat_dot)
      begin
         color_next = cur_line.pattern_bg_color;
         csel_next = cur_line.pattern_bg_chroma;
         blank_next = 1'b1;
      end
      else if (shade_on)
      begin
         // Inversion swaps the bevel so the cell looks pressed in
         if (light)
            color_next = inv ? EDGE_DARK : EDGE_LIGHT;
         else if (dark)
            color_next = inv ? EDGE_LIGHT : EDGE_DARK;
         else
            color_next = SHADE_FILL;
         csel_next = screen2_reg[S2_CBG];
         blank_next = 1'b1;
      end
      else if (screen1_reg[S1_CBG] & dot_in.qualify_flag)
      begin
         color_next = dot_in.char_bg_color;
         csel_next = screen2_reg[S2_CBG];
         blank_next = 1'b1;
      end
      else if (screen2_reg[S2_UON])
         color_next = screen2_reg[3:0];
      spec_next = screen2_reg[S2_HL] & screen1_reg[S1_DC] & dot_in.active
         & dot_in.qualify_flag;
   end

   // Registered pin drivers, one dot of latency
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         {intensity_out, green_out, red_out, blue_out} <= RST_ZERO4;
         color_select_out <= 1'b0;
         all_output_blank <= 1'b0;
         specified_char_blank <= 1'b0;
      end
      else
      begin
         {intensity_out, green_out, red_out, blue_out} <= color_next;
         color_select_out <= csel_next;
         all_output_blank <= blank_next;
         specified_char_blank <= spec_next;
      end
   end

   assign avs_waitrequest = wait_reg;
   assign avs_readdata = rdata_reg;

   a_line1_held: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (take & avs_write & avs_address == OFF_LINE1) |=> $stable(column_reg))
      else $error("first line word moved the column");

   a_line2_store: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (wr_line2 && column_reg <= LAST_COL) |=>
      line_ram[$past(column_reg)] == {$past(line_hold_reg[13:5]),
      $past(avs_writedata[4:0])})
      else $error("line entry not stored at column");

   a_column_bump: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (wr_line2 && column_reg < LAST_COL) |=> column_reg == $past(column_reg) + 4'h1)
      else $error("column did not advance");

   a_bus_wait: assert property (
      @(posedge core_clk) disable iff (!rstn)
      ((avs_read | avs_write) & wait_reg) |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("waitrequest sequence broken");

   a_vstart_dots: assert property (
      @(posedge core_clk) disable iff (!rstn)
      $stable(vstart_reg) |=> timing_out.vstart_dots == {$past(vstart_reg), 1'b0})
      else $error("vertical start not two dots per step");

   a_size_shift: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (cur_line.glyph_size_select == OSDLSC_SZ_QW) |=>
      timing_out.line_hstart_dots == {1'b0, $past(hbase_reg), 3'h0}
      + 11'($past(cur_line.line_hstart_offset)) * OFS_STEP_DOTS
      + 11'h009)
      else $error("quadruple width shift is not nine dots");

   a_display_off: assert property (
      @(posedge core_clk) disable iff (!rstn)
      !screen1_reg[S1_DC] |=> !all_output_blank && !specified_char_blank)
      else $error("output while display disabled");

   a_screen_off: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (!screen1_reg[S1_DC] && !screen2_reg[S2_UON]) |=>
      {intensity_out, green_out, red_out, blue_out} == 4'h0)
      else $error("screen background not held low");

   a_screen_chroma: assert property (
      @(posedge core_clk) disable iff (!rstn)
      !dot_in.active |=> color_select_out == $past(screen2_reg[S2_UC]))
      else $error("color select ignores screen chroma");

   a_highlight_off: assert property (
      @(posedge core_clk) disable iff (!rstn)
      !screen2_reg[S2_HL] |=> !specified_char_blank)
      else $error("highlight output without enable");

   // Column, pin and geometry checks; each looks one dot after its cause
   a_column_wrap: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (wr_line2 && column_reg >= LAST_COL) |=> column_reg == RST_ZERO4)
      else $error("column did not wrap to zero");

   a_spacing_dots: assert property (
      @(posedge core_clk) disable iff (!rstn)
      rstn |=> timing_out.spacing_dots == {$past(screen1_reg[S1_SPACE +: 4]), 1'b0})
      else $error("line spacing not two dots per step");

   a_frame_short: assert property (
      @(posedge core_clk) disable iff (!rstn)
      screen1_reg[S1_K24] |=> timing_out.shadow_frame_height == FRAME_SHORT)
      else $error("shadow frame not 24 dots");

   a_sprite_chroma: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (screen1_reg[S1_DC] && dot_in.active && dot_in.sprite_dot) |=>
      (color_select_out == $past(screen2_reg[S2_SPR]) && all_output_blank))
      else $error("sprite dot ignores sprite chroma");

   a_char_chroma: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (screen1_reg[S1_DC] && dot_in.active && !dot_in.sprite_dot && dot_in.font_bit
      && !(screen1_reg[S1_BLINK] && dot_in.qualify_flag && dot_in.blink_phase)) |=>
      color_select_out == $past(screen2_reg[S2_CHR]))
      else $error("character dot ignores character chroma");

   a_pattern_chroma: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (screen1_reg[S1_DC] && dot_in.active && !dot_in.sprite_dot && !dot_in.font_bit
      && screen1_reg[S1_PMODE] && dot_in.font_nbr) |=>
      color_select_out == $past(cur_line.pattern_bg_chroma))
      else $error("pattern dot ignores pattern chroma");

   a_bg_shown: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (!screen1_reg[S1_DC] && screen2_reg[S2_UON]) |=>
      ({intensity_out, green_out, red_out, blue_out} == $past(screen2_reg[3:0])
      && !all_output_blank))
      else $error("screen background color not shown");

   a_highlight_on: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (screen2_reg[S2_HL] && screen1_reg[S1_DC] && dot_in.active && dot_in.qualify_flag)
      |=> specified_char_blank)
      else $error("qualified cell not marked");
endmodule

// file: sim/osdlsc_host.sv
/*
 Host model: an Avalon-MM master that issues the display commands.
 Assumes one core clock and a slave whose waitrequest is registered.
*/
`timescale 1ns/1ns
module osdlsc_host
   import osdlsc_pkg::*;
(
   input wire logic core_clk,
   output logic [4:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest
);
   // Bus idle at time zero
   initial
   begin
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
   end

   // One transfer; the request is held until waitrequest is seen low at an edge
   task automatic xfer(input logic [4:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q);
      logic [31:0] v;
      v = d;
      // The two forbidden size codes are never sent; a real host avoids them too
      if (a == OFF_LINE1 && v[5])
         v[3] = 1'b0;
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= v;
      avs_write <= w;
      avs_read <= ~w;
      do
         @(posedge core_clk);
      while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
endmodule

// file: sim/osd_line_screen_control_test.sv
/*
 Self-checking bench for the line and screen control block.
 Assumes the host model drives the register bus and the bench the dots.
*/
`timescale 1ns/1ns
module osd_line_screen_control_test
   import osdlsc_pkg::*;
;
   logic core_clk, rstn, avs_read, avs_write, avs_waitrequest;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic red_out, green_out, blue_out, intensity_out;
   logic color_select_out, all_output_blank, specified_char_blank;
   osdlsc_dot_t dot_in, d;
   osdlsc_timing_t timing_out;
   int num_errors, checked;
   // Rows: screen control 1, screen control 2, dot flags, {color, select, blank, highlight}
   logic [34:0] rows [16] = '{
      {11'h001, 11'h413, 6'h01, 7'h66},
      {11'h001, 11'h013, 6'h10, 7'h2a},
      {11'h001, 11'h213, 6'h10, 7'h2e},
      {11'h000, 11'h033, 6'h10, 7'h1c},
      {11'h001, 11'h020, 6'h00, 7'h04},
      {11'h003, 11'h013, 6'h08, 7'h4e},
      {11'h001, 11'h013, 6'h08, 7'h18},
      {11'h201, 11'h113, 6'h04, 7'h56},
      {11'h001, 11'h113, 6'h04, 7'h18},
      {11'h101, 11'h013, 6'h34, 7'h18},
      {11'h001, 11'h013, 6'h34, 7'h2a},
      {11'h001, 11'h053, 6'h04, 7'h19},
      {11'h401, 11'h213, 6'h16, 7'h56},
      {11'h001, 11'h213, 6'h16, 7'h2e},
      {11'h001, 11'h113, 6'h02, 7'h3e},
      {11'h201, 11'h053, 6'h00, 7'h18}
   };

   osdlsc_top DUT (
      .core_clk(core_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .dot_in(dot_in), .red_out(red_out),
      .green_out(green_out), .blue_out(blue_out), .intensity_out(intensity_out),
      .color_select_out(color_select_out), .all_output_blank(all_output_blank),
      .specified_char_blank(specified_char_blank), .timing_out(timing_out));

   osdlsc_host host (
      .core_clk(core_clk), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));

   // 10 MHz core clock
   initial
   begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   // Interior dot with fixed colors: char 5, background a, sprite c
   function automatic osdlsc_dot_t mk(input logic [5:0] f);
      mk = {$bits(osdlsc_dot_t){1'b0}};
      mk.active = 1'b1;
      mk.cell_x = 5'h05;
      mk.cell_y = 5'h05;
      {mk.blink_phase, mk.font_bit, mk.font_nbr} = f[5:3];
      {mk.qualify_flag, mk.shade_flag, mk.sprite_dot} = f[2:0];
      mk.char_color = 4'h5;
      mk.char_bg_color = 4'ha;
      mk.sprite_color = 4'hc;
   endfunction

   // A compare; with ne set, equality is the failure
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g,
                      input logic ne);
      checked++;
      if (ne ? (g === e || $isunknown(g)) : (g !== e))
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] v);
      host.xfer(a, 1'b1, v, q);
   endtask

   task automatic rdc(input string n, input logic [4:0] a, input logic [31:0] e);
      host.xfer(a, 1'b0, 32'h0, q);
      chk(n, e, q, 1'b0);
   endtask

   // Dot outputs are registered, so look one edge after the dot is driven
   task automatic apply(input osdlsc_dot_t v);
      @(posedge core_clk);
      dot_in <= v;
      @(posedge core_clk);
      #1;
   endtask

   // Line entry 0 written from column zero: first part, then second part
   task automatic line0(input logic [31:0] l1);
      wr(OFF_COLUMN, 32'h0);
      wr(OFF_LINE1, l1);
      wr(OFF_LINE2, 32'h19);
   endtask

   // Shaded dot at a cell position; compares the color with the shade fill
   task automatic shade(input logic [4:0] cx, input logic [4:0] cy, input logic ne);
      d = mk(6'h02);
      d.cell_x = cx;
      d.cell_y = cy;
      d.left_shade = (cx == 5'h00);
      apply(d);
      chk("shade", 32'h7, {28'h0, intensity_out, green_out, red_out, blue_out}, ne);
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Cuts a hang short after about 5000 cycles
   initial
   begin
      #500000;
      num_errors++;
      end_of_test();
   end

   // Main sequence: reset, table rows, then hand-written cases
   initial
   begin
      num_errors = 0;
      checked = 0;
      rstn = 1'b0;
      dot_in = {$bits(osdlsc_dot_t){1'b0}};
      repeat (5) @(posedge core_clk);
      #1;
      chk("wait in reset", 32'h1, {31'h0, avs_waitrequest}, 1'b0);
      chk("timing in reset", 32'h0, {31'h0, |timing_out}, 1'b0);
      @(posedge core_clk);
      rstn <= 1'b1;
      rdc("screen1 reset", OFF_SCREEN1, 32'h0);
      rdc("column reset", OFF_COLUMN, 32'h0);
      wr(OFF_HSTART, 32'h5);
      line0(32'h720);
      $display("test reset done");
      foreach (rows[i])
      begin
         wr(OFF_SCREEN1, {21'h0, rows[i][34:24]});
         wr(OFF_SCREEN2, {21'h0, rows[i][23:13]});
         apply(mk(rows[i][12:7]));
         chk("dot row", {25'h0, rows[i][6:0]}, {25'h0, intensity_out, green_out, red_out,
             blue_out, color_select_out, all_output_blank, specified_char_blank}, 1'b0);
      end
      $display("test rows done");
      // Held first part leaves line 1 untouched until the second part
      wr(OFF_LINE1, 32'h108);
      d = mk(6'h00);
      d.line_idx = 4'h1;
      apply(d);
      chk("held line", 32'h28, {21'h0, timing_out.line_hstart_dots}, 1'b0);
      rdc("line1 held", OFF_LINE1, 32'h900);
      wr(OFF_LINE2, 32'h0);
      apply(d);
      chk("line1 start", 32'h5b, {21'h0, timing_out.line_hstart_dots}, 1'b0);
      chk("line1 size", 32'h1, {29'h0, timing_out.glyph_size_select}, 1'b0);
      apply(mk(6'h00));
      chk("line0 start", 32'h181, {21'h0, timing_out.line_hstart_dots}, 1'b0);
      rdc("column step", OFF_COLUMN, 32'h2);
      rdc("status", OFF_STATUS, 32'h181);
      rdc("line2 wo", OFF_LINE2, 32'h0);
      wr(OFF_COLUMN, 32'hb);
      wr(OFF_LINE2, 32'h0);
      rdc("column wrap", OFF_COLUMN, 32'h0);
      $display("test lines done");
      wr(OFF_SCREEN1, 32'h7d);
      wr(OFF_VSTART, 32'h7f);
      wr(OFF_SCREEN2, 32'h113);
      apply(mk(6'h00));
      chk("spacing", 32'h1e, {27'h0, timing_out.spacing_dots}, 1'b0);
      chk("frame24", 32'h18, {26'h0, timing_out.shadow_frame_height}, 1'b0);
      chk("vstart", 32'hfe, {24'h0, timing_out.vstart_dots}, 1'b0);
      wr(OFF_SCREEN1, 32'h1);
      apply(mk(6'h00));
      chk("frame32", 32'h20, {26'h0, timing_out.shadow_frame_height}, 1'b0);
      $display("test screen done");
      shade(5'h05, 5'h1f, 1'b1);
      shade(5'h05, 5'h00, 1'b1);
      shade(5'h00, 5'h05, 1'b0);
      line0(32'h727);
      shade(5'h05, 5'h1f, 1'b0);
      shade(5'h05, 5'h00, 1'b0);
      shade(5'h00, 5'h05, 1'b1);
      $display("test shade done");
      // Second reset in mid-run clears the settings again
      @(posedge core_clk);
      rstn <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      chk("wait in reset2", 32'h1, {31'h0, avs_waitrequest}, 1'b0);
      chk("timing in reset2", 32'h0, {31'h0, |timing_out}, 1'b0);
      @(posedge core_clk);
      rstn <= 1'b1;
      rdc("screen1 reset2", OFF_SCREEN1, 32'h0);
      $display("test second reset done");
      end_of_test();
   end
endmodule
